// File: inc/lcd_drv_pkg.sv
// Constants shared by the dual-channel serial display driver.
package lcd_drv_pkg;
	localparam int          CH_WIDTH      = 20;
	localparam int          NUM_CH        = 2;
	localparam int          SYNC_STAGES   = 3;
	localparam int          BUF_DEPTH     = 2;
	localparam int          CODE_W        = 3;
	// Register byte offsets.
	localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
	localparam logic [7:0]  STATUS_OFFSET = 8'h04;
	localparam logic [7:0]  LATCH1_OFFSET = 8'h08;
	localparam logic [7:0]  LATCH2_OFFSET = 8'h0C;
	// Control fields.
	localparam int          CTRL_HOLD1_BIT = 0;
	localparam int          CTRL_HOLD2_BIT = 1;
	localparam logic [1:0]  CTRL_RESET     = 2'h0;
	// Status fields.
	localparam int          ST_DIR1_BIT    = 0;
	localparam int          ST_DIR2_BIT    = 1;
	localparam int          ST_MODE_BIT    = 2;
	localparam int          ST_ALT_BIT     = 3;
	localparam int          ST_COUNT1_LSB  = 4;
	localparam int          ST_COUNT2_LSB  = 6;
	localparam int          ST_OVF1_BIT    = 8;
	localparam int          ST_OVF2_BIT    = 9;
	// Drive level codes on each output.
	localparam logic [2:0]  LEVEL_NONE    = 3'h0;
	localparam logic [2:0]  LEVEL_1       = 3'h1;
	localparam logic [2:0]  LEVEL_2       = 3'h2;
	localparam logic [2:0]  LEVEL_3       = 3'h3;
	localparam logic [2:0]  LEVEL_4       = 3'h4;
	localparam logic [2:0]  LEVEL_5       = 3'h5;
	localparam logic [2:0]  LEVEL_6       = 3'h6;
	// Synchronised input bit positions.
	localparam int          IN_LATCH_CLK  = 0;
	localparam int          IN_SHIFT_CLK  = 1;
	localparam int          IN_DIR1       = 2;
	localparam int          IN_DIR2       = 3;
	localparam int          IN_MODE       = 4;
	localparam int          IN_ALT        = 5;
	localparam int          IN_L1         = 6;
	localparam int          IN_R1         = 7;
	localparam int          IN_L2         = 8;
	localparam int          IN_R2         = 9;
	localparam int          IN_COUNT      = 10;
endpackage : lcd_drv_pkg

// File: verilog/lcd_serial_driver.sv
// Dual-channel serial-to-parallel display driver with an APB register port.
//
// Overview of operation
// - Two channels, each 20-bit bidirectional shifter.
// - Serial display bits become parallel drive values.
// - 20-bit latch per channel; outputs 1-20, 21-40.
// - Channel 1 strap picks shift direction, pin roles.
// - Channel 2 strap does likewise for channel 2.
// - Serial pin pair is shifter input and output.
// - Channel 1 latches on falling latch clock.
// - Channel 1 shifts on falling shift clock.
// - Mode low: both channels use channel 1 edges.
// - Mode high: channel 2 uses rising swapped clocks.
// - Mode strap swaps clocks, inverts alternation.
// - Alternation toggles selected and non-selected levels.
// - Level from bit, alternation and mode strap.
// - Levels 1-2 select; 3-4, 5-6 non-select.
// - New levels follow falling latch clock; channel 2 in mode high, rising shift clock.
`timescale 1ns/100ps
`default_nettype none
module lcd_serial_driver
	import lcd_drv_pkg::*;
(
	// Clock and reset.
	input  wire logic                                      clk,
	input  wire logic                                      nrst,
	// APB slave.
	input  wire logic                                      psel,
	input  wire logic                                      penable,
	input  wire logic                                      pwrite,
	input  wire logic [7:0]                                paddr,
	input  wire logic [31:0]                               pwdata,
	output logic                                           pready,
	output logic [31:0]                                    prdata,
	output logic                                           pslverr,
	// Controller timing and mode pins.
	input  wire logic                                      latch_clock_in,
	input  wire logic                                      shift_clock_in,
	input  wire logic                                      alternation_in,
	input  wire logic                                      ch1_direction_strap,
	input  wire logic                                      ch2_direction_strap,
	input  wire logic                                      ch2_mode_strap,
	// Channel 1 serial pins.
	input  wire logic                                      ch1_left_serial_pin_in,
	output logic                                           ch1_left_serial_pin_out,
	output logic                                           ch1_left_serial_pin_oe,
	input  wire logic                                      ch1_right_serial_pin_in,
	output logic                                           ch1_right_serial_pin_out,
	output logic                                           ch1_right_serial_pin_oe,
	// Channel 2 serial pins.
	input  wire logic                                      ch2_left_serial_pin_in,
	output logic                                           ch2_left_serial_pin_out,
	output logic                                           ch2_left_serial_pin_oe,
	input  wire logic                                      ch2_right_serial_pin_in,
	output logic                                           ch2_right_serial_pin_out,
	output logic                                           ch2_right_serial_pin_oe,
	// Drive level codes, output k at [k-1].
	output logic [lcd_drv_pkg::NUM_CH*lcd_drv_pkg::CH_WIDTH-1:0][lcd_drv_pkg::CODE_W-1:0] drive_outputs
);
	import lcd_drv_pkg::*;

	logic [IN_COUNT-1:0]             raw_in;
	logic [IN_COUNT-1:0]             sync1;
	logic [IN_COUNT-1:0]             sync2;
	logic [IN_COUNT-1:0]             sync3;
	logic [IN_COUNT-1:0]             filt;
	logic [IN_COUNT-1:0]             filt_prev;
	logic                            latch_fall;
	logic                            latch_rise;
	logic                            shift_fall;
	logic                            shift_rise;
	logic [2:0]                      warm_count;
	logic                            edges_armed;
	logic [NUM_CH-1:0]               dir;
	logic [NUM_CH-1:0]               left_in;
	logic [NUM_CH-1:0]               right_in;
	logic [NUM_CH-1:0]               shift_evt;
	logic [NUM_CH-1:0]               latch_evt;
	logic [NUM_CH-1:0]               alt_eff;
	logic [NUM_CH-1:0][CH_WIDTH-1:0] shift_reg;
	logic [NUM_CH-1:0][CH_WIDTH-1:0] latch_reg;
	logic [NUM_CH-1:0]               buf_in_ready;
	logic [NUM_CH-1:0]               buf_out_valid;
	logic [NUM_CH-1:0]               buf_out_ready;
	logic [NUM_CH-1:0][CH_WIDTH-1:0] buf_out_data;
	logic [NUM_CH-1:0][1:0]          buf_count;
	logic [NUM_CH-1:0]               overflow;
	logic [1:0]                      ctrl_hold;
	logic                            wr_access;
	logic                            rd_setup;
	logic                            addr_hit;
	logic [31:0]                     next_prdata;
	logic [31:0]                     status_word;

	assign raw_in = {ch2_right_serial_pin_in, ch2_left_serial_pin_in, ch1_right_serial_pin_in,
		ch1_left_serial_pin_in, alternation_in, ch2_mode_strap, ch2_direction_strap,
		ch1_direction_strap, shift_clock_in, latch_clock_in};

	// Pins are asynchronous to clk; a level change counts only once stages two and three agree.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1     <= '0;
			sync2     <= '0;
			sync3     <= '0;
			filt      <= '0;
			filt_prev <= '0;
		end else begin
			sync1     <= raw_in;
			sync2     <= sync1;
			sync3     <= sync2;
			filt      <= (sync2 == sync3) ? sync3 : filt;
			filt_prev <= filt;
		end
	end

	// Reset clears the filter whatever the pins show, so a clock pin resting high would look like a
	// rising edge; edges stay masked until the filter and its delayed copy have both caught up.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			warm_count <= 3'h0;
		end else if (!edges_armed) begin
			warm_count <= warm_count + 3'h1;
		end
	end

	assign edges_armed = (warm_count == 3'(SYNC_STAGES) + 3'h2);

	assign latch_fall = edges_armed & filt_prev[IN_LATCH_CLK] & ~filt[IN_LATCH_CLK];
	assign latch_rise = edges_armed & ~filt_prev[IN_LATCH_CLK] & filt[IN_LATCH_CLK];
	assign shift_fall = edges_armed & filt_prev[IN_SHIFT_CLK] & ~filt[IN_SHIFT_CLK];
	assign shift_rise = edges_armed & ~filt_prev[IN_SHIFT_CLK] & filt[IN_SHIFT_CLK];

	assign dir      = {filt[IN_DIR2], filt[IN_DIR1]};
	assign left_in  = {filt[IN_L2], filt[IN_L1]};
	assign right_in = {filt[IN_R2], filt[IN_R1]};

	assign shift_evt[0] = shift_fall;
	assign latch_evt[0] = latch_fall;
	assign shift_evt[1] = filt[IN_MODE] ? latch_rise : shift_fall;
	assign latch_evt[1] = filt[IN_MODE] ? shift_rise : latch_fall;
	assign alt_eff[0]   = filt[IN_ALT];
	assign alt_eff[1]   = filt[IN_ALT] ^ filt[IN_MODE];

	// Serial pins: a high strap makes the left pin the output, a low strap the right pin.
	assign ch1_left_serial_pin_out  = shift_reg[0][0];
	assign ch1_left_serial_pin_oe   = dir[0];
	assign ch1_right_serial_pin_out = shift_reg[0][CH_WIDTH-1];
	assign ch1_right_serial_pin_oe  = ~dir[0];
	assign ch2_left_serial_pin_out  = shift_reg[1][0];
	assign ch2_left_serial_pin_oe   = dir[1];
	assign ch2_right_serial_pin_out = shift_reg[1][CH_WIDTH-1];
	assign ch2_right_serial_pin_oe  = ~dir[1];

	assign buf_out_ready = ~ctrl_hold;

	genvar ch;
	genvar b;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			logic [BUF_DEPTH-1:0][CH_WIDTH-1:0] buf_mem;
			logic                               wr_ptr;
			logic                               rd_ptr;
			logic                               push;
			logic                               pop;

			// Bidirectional shift: high strap enters at the right and moves left.
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					shift_reg[ch] <= '0;
				end else if (shift_evt[ch]) begin
					if (dir[ch]) begin
						shift_reg[ch] <= {right_in[ch], shift_reg[ch][CH_WIDTH-1:1]};
					end else begin
						shift_reg[ch] <= {shift_reg[ch][CH_WIDTH-2:0], left_in[ch]};
					end
				end
			end

			// Two-entry buffer between shifter snapshot and latch; hold stalls the drain.
			assign buf_in_ready[ch]  = (buf_count[ch] != 2'h2);
			assign buf_out_valid[ch] = (buf_count[ch] != 2'h0);
			assign buf_out_data[ch]  = buf_mem[rd_ptr];
			assign push              = latch_evt[ch] & buf_in_ready[ch];
			assign pop               = buf_out_valid[ch] & buf_out_ready[ch];

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					buf_mem <= '0;
					wr_ptr  <= 1'b0;
				end else if (push) begin
					buf_mem[wr_ptr] <= shift_reg[ch];
					wr_ptr          <= ~wr_ptr;
				end
			end

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					rd_ptr <= 1'b0;
				end else if (pop) begin
					rd_ptr <= ~rd_ptr;
				end
			end

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					buf_count[ch] <= 2'h0;
				end else if (push && !pop) begin
					buf_count[ch] <= buf_count[ch] + 2'h1;
				end else if (pop && !push) begin
					buf_count[ch] <= buf_count[ch] - 2'h1;
				end
			end

			// A latch edge meeting a full buffer is lost; the sticky flag records it.
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					overflow[ch] <= 1'b0;
				end else if (latch_evt[ch] && !buf_in_ready[ch]) begin
					overflow[ch] <= 1'b1;
				end else if (wr_access && paddr == STATUS_OFFSET && pwdata[ST_OVF1_BIT + ch]) begin
					overflow[ch] <= 1'b0;
				end
			end

			// All bits transfer together and stay put while shifting goes on.
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					latch_reg[ch] <= '0;
				end else if (pop) begin
					latch_reg[ch] <= buf_out_data[ch];
				end
			end

			for (b = 0; b < CH_WIDTH; b++) begin : g_bit
				logic [CODE_W-1:0] next_code;

				// Select uses levels 1/2; non-select uses 3/4 or 5/6 by channel.
				always_comb begin
					if (latch_reg[ch][b]) begin
						next_code = alt_eff[ch] ? LEVEL_1 : LEVEL_2;
					end else if (ch == 0) begin
						next_code = alt_eff[ch] ? LEVEL_4 : LEVEL_3;
					end else begin
						next_code = alt_eff[ch] ? LEVEL_6 : LEVEL_5;
					end
				end

				always_ff @(posedge clk or negedge nrst) begin
					if (!nrst) begin
						drive_outputs[ch*CH_WIDTH + b] <= LEVEL_NONE;
					end else begin
						drive_outputs[ch*CH_WIDTH + b] <= next_code;
					end
				end
			end
		end
	endgenerate

	// APB: zero wait states; read data is captured in the setup phase.
	assign wr_access = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable;
	assign pready    = 1'b1;
	assign addr_hit  = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET) ||
		(paddr == LATCH1_OFFSET) || (paddr == LATCH2_OFFSET);

	always_comb begin
		status_word                                        = 32'h0;
		status_word[ST_DIR1_BIT]                           = dir[0];
		status_word[ST_DIR2_BIT]                           = dir[1];
		status_word[ST_MODE_BIT]                           = filt[IN_MODE];
		status_word[ST_ALT_BIT]                            = filt[IN_ALT];
		status_word[ST_COUNT1_LSB +: 2]                    = buf_count[0];
		status_word[ST_COUNT2_LSB +: 2]                    = buf_count[1];
		status_word[ST_OVF1_BIT]                           = overflow[0];
		status_word[ST_OVF2_BIT]                           = overflow[1];
	end

	always_comb begin
		case (paddr)
			CTRL_OFFSET:   next_prdata = {30'h0, ctrl_hold};
			STATUS_OFFSET: next_prdata = status_word;
			LATCH1_OFFSET: next_prdata = {12'h0, latch_reg[0]};
			LATCH2_OFFSET: next_prdata = {12'h0, latch_reg[1]};
			default:       next_prdata = 32'h0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata  <= pwrite ? 32'h0 : next_prdata;
			pslverr <= ~addr_hit;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_hold <= CTRL_RESET;
		end else if (wr_access && paddr == CTRL_OFFSET) begin
			ctrl_hold <= {pwdata[CTRL_HOLD2_BIT], pwdata[CTRL_HOLD1_BIT]};
		end
	end
endmodule : lcd_serial_driver
`default_nettype wire

// File: verification/lcd_driver_properties.sv
// Checker for the driver's serial pin roles and drive level codes.
`timescale 1ns/100ps
`default_nettype none
module lcd_driver_properties
	import lcd_drv_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Activity that can move the codes.
	input wire logic psel,
	input wire logic latch_clock_in,
	input wire logic shift_clock_in,
	input wire logic alternation_in,
	input wire logic ch2_mode_strap,
	// Straps and pin enables.
	input wire logic ch1_direction_strap,
	input wire logic ch2_direction_strap,
	input wire logic ch1_left_serial_pin_oe,
	input wire logic ch1_right_serial_pin_oe,
	input wire logic ch2_left_serial_pin_oe,
	input wire logic ch2_right_serial_pin_oe,
	// Drive level codes.
	input wire logic [lcd_drv_pkg::NUM_CH*lcd_drv_pkg::CH_WIDTH-1:0][lcd_drv_pkg::CODE_W-1:0] drive_outputs
);
	logic [3:0] prev;
	logic [4:0] quiet;
	logic       bad1, bad2, bad_alt;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Pin to code takes about seven cycles, so twelve quiet cycles leave margin for the filter.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev  <= 4'h0;
			quiet <= 5'h00;
		end else begin
			prev <= {latch_clock_in, shift_clock_in, alternation_in, ch2_mode_strap};
			if (psel || prev != {latch_clock_in, shift_clock_in, alternation_in, ch2_mode_strap}) quiet <= 5'h00;
			else if (quiet != 5'h1F) quiet <= quiet + 5'h01;
		end
	end
	always_comb begin
		bad1 = 1'b0;
		bad2 = 1'b0;
		bad_alt = 1'b0;
		for (int k = 0; k < CH_WIDTH; k++) begin
			bad1 |= !(drive_outputs[k] inside {[LEVEL_1:LEVEL_4]});
			bad2 |= !(drive_outputs[k+CH_WIDTH] inside {LEVEL_1, LEVEL_2, LEVEL_5, LEVEL_6});
			bad_alt |= (drive_outputs[k] inside {LEVEL_1, LEVEL_4}) != alternation_in;
			bad_alt |= (drive_outputs[k+CH_WIDTH] inside {LEVEL_1, LEVEL_6}) != (alternation_in ^ ch2_mode_strap);
		end
	end
	sequence settled;
		quiet >= 5'h0C;
	endsequence
	sequence dir1_high;
		ch1_direction_strap [*8];
	endsequence
	sequence dir2_low;
		(!ch2_direction_strap) [*8];
	endsequence
	AST_CH1_ONE_END: assert property (ch1_left_serial_pin_oe != ch1_right_serial_pin_oe)
		else $error("ch1 serial pin roles wrong");
	AST_CH2_ONE_END: assert property (ch2_left_serial_pin_oe != ch2_right_serial_pin_oe)
		else $error("ch2 serial pin roles wrong");
	AST_CH1_DIR: assert property (dir1_high |-> ch1_left_serial_pin_oe)
		else $error("ch1 left pin not driving");
	AST_CH2_DIR: assert property (dir2_low |-> ch2_right_serial_pin_oe)
		else $error("ch2 right pin not driving");
	AST_CH1_LEVELS: assert property (settled |-> !bad1)
		else $error("ch1 code outside its levels");
	AST_CH2_LEVELS: assert property (settled |-> !bad2)
		else $error("ch2 code outside its levels");
	AST_ALT_LEVELS: assert property (settled |-> !bad_alt)
		else $error("code disagrees with alternation");
	AST_DRIVE_HOLD: assert property (settled |=> $stable(drive_outputs))
		else $error("codes moved without a cause");
endmodule : lcd_driver_properties
`default_nettype wire

// File: verification/lcd_controller_model.sv
// Behavioural display controller that clocks serial bits into the driver.
`timescale 1ns/100ps
`default_nettype none
module lcd_controller_model (
	// Clock.
	input wire logic clk,
	// Pins towards the driver.
	output logic     latch_clk,
	output logic     shift_clk,
	output logic     ch1_data,
	output logic     ch2_data
);
	initial {latch_clk, shift_clk, ch1_data, ch2_data} = 4'h0;
	// Eight cycles around each edge keep data clear of the driver's input filter.
	task automatic pulse(input logic kind, input logic a, input logic b);
		@(posedge clk);
		{ch1_data, ch2_data} <= {a, b};
		repeat (8) @(posedge clk);
		{latch_clk, shift_clk} <= {kind, !kind};
		repeat (8) @(posedge clk);
		{latch_clk, shift_clk} <= 2'h0;
		repeat (8) @(posedge clk);
		// Hold time is over, so the lines show the inverse rather than a stale copy.
		{ch1_data, ch2_data} <= {!a, !b};
	endtask : pulse
endmodule : lcd_controller_model
`default_nettype wire

// File: verification/lcd_serial_driver_test.sv
// Self-checking bench for the dual-channel serial display driver.
`timescale 1ns/100ps
`default_nettype none
module lcd_serial_driver_test;
	import lcd_drv_pkg::*;
	logic	clk, nrst, psel, penable, pwrite, pready, pslverr, snap_req, alt, dir1, dir2, mode;
	logic	latch_clk, shift_clk, ch1_data, ch2_data, l1o, l1e, r1o, r1e, l2o, l2e, r2o, r2e;
	logic [7:0]	paddr;
	logic [31:0]	pwdata, prdata;
	logic [NUM_CH*CH_WIDTH-1:0][CODE_W-1:0]	drive;
	logic [1:0][19:0]	sr, lat;
	logic [1:0]	hold, ovf;
	logic [19:0]	rq[2][$];
	logic [32:0]	apb_q[$];
	logic [121:0]	drv_q[$];
	int	err_count, comparisons, cycles;
	wire	l1i = l1e ? l1o : ch1_data;
	wire	r1i = r1e ? r1o : ch1_data;
	wire	l2i = l2e ? l2o : ch2_data;
	wire	r2i = r2e ? r2o : ch2_data;
	lcd_serial_driver lcd_serial_driver_i (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .latch_clock_in(latch_clk),
		.shift_clock_in(shift_clk), .alternation_in(alt), .ch1_direction_strap(dir1), .ch2_direction_strap(dir2),
		.ch2_mode_strap(mode), .ch1_left_serial_pin_in(l1i), .ch1_left_serial_pin_out(l1o), .ch1_left_serial_pin_oe(l1e),
		.ch1_right_serial_pin_in(r1i), .ch1_right_serial_pin_out(r1o), .ch1_right_serial_pin_oe(r1e),
		.ch2_left_serial_pin_in(l2i), .ch2_left_serial_pin_out(l2o), .ch2_left_serial_pin_oe(l2e),
		.ch2_right_serial_pin_in(r2i), .ch2_right_serial_pin_out(r2o), .ch2_right_serial_pin_oe(r2e), .drive_outputs(drive));
	lcd_controller_model lcd_controller_model_i (.clk(clk), .latch_clk(latch_clk), .shift_clk(shift_clk),
		.ch1_data(ch1_data), .ch2_data(ch2_data));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		if (err_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : complete_run
	task automatic check(input string name, input logic [121:0] seen, input logic [121:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic ref_edge(input int c, input logic is_lat, input logic d);
		if (!is_lat) sr[c] = (c ? dir2 : dir1) ? {d, sr[c][19:1]} : {sr[c][18:0], d};
		else if (!hold[c]) lat[c] = sr[c];
		else if (rq[c].size() < BUF_DEPTH) rq[c].push_back(sr[c]);
		else ovf[c] = 1'b1;
	endtask : ref_edge
	task automatic pulse(input logic kind);
		logic a, b;
		a = 1'($urandom);
		b = 1'($urandom);
		lcd_controller_model_i.pulse(kind, a, b);
		if (mode) ref_edge(1, !kind, b);
		ref_edge(0, kind, a);
		if (!mode) ref_edge(1, kind, b);
	endtask : pulse
	function automatic logic [121:0] expected();
		logic [121:0] v;
		logic ae;
		for (int k = 0; k < 2 * CH_WIDTH; k++) begin
			ae = (k < CH_WIDTH) ? alt : alt ^ mode;
			if (lat[k/CH_WIDTH][k%CH_WIDTH]) v[3*k+:3] = ae ? LEVEL_1 : LEVEL_2;
			else if (k < CH_WIDTH) v[3*k+:3] = ae ? LEVEL_4 : LEVEL_3;
			else v[3*k+:3] = ae ? LEVEL_6 : LEVEL_5;
		end
		v[121:120] = {dir1 ? sr[0][0] : sr[0][19], dir2 ? sr[1][0] : sr[1][19]};
		return v;
	endfunction : expected
	function automatic logic [32:0] stat();
		return {23'h0, ovf, 2'(rq[1].size()), 2'(rq[0].size()), alt, mode, dir2, dir1};
	endfunction : stat
	task automatic snap();
		repeat (12) @(posedge clk);
		drv_q.push_back(expected());
		snap_req <= 1'b1;
		@(posedge clk);
		snap_req <= 1'b0;
	endtask : snap
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
		apb_q.push_back(exp);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// Ends when pready is high; otherwise only the bench's cycle ceiling ends this wait.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		{psel, penable} <= 2'h0;
	endtask : apb
	always @(posedge clk) begin
		cycles++;
		if (psel && penable && pready) check("apb", {pslverr, prdata}, apb_q.pop_front());
		if (snap_req) check("drive", {dir1 ? l1o : r1o, dir2 ? l2o : r2o, drive}, drv_q.pop_front());
		if (cycles == 30000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, snap_req, alt, dir1, dir2, mode} = '0;
		{sr, lat, hold, ovf, err_count, comparisons, cycles} = '0;
		void'($urandom(32'h14813650));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		snap();
		apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF, 33'h1_0000_0000);
		for (int i = 0; i < 8; i++) begin
			{mode, dir2, dir1} <= 3'(i);
			alt <= 1'($urandom);
			repeat (10) @(posedge clk);
			for (int k = 0; k < 41; k++) pulse($urandom_range(3) == 0);
			snap();
			apb(1'b0, LATCH1_OFFSET, 32'h0, {13'h0, lat[0]});
			apb(1'b0, LATCH2_OFFSET, 32'h0, {13'h0, lat[1]});
			apb(1'b0, STATUS_OFFSET, 32'h0, stat());
		end
		// Holding both latches: channel 1 gets three loads, two fill the buffer and the third is refused; channel 2, in mode high, gets sixty.
		apb(1'b1, CTRL_OFFSET, 32'h3, 33'h0);
		hold = 2'h3;
		apb(1'b0, CTRL_OFFSET, 32'h0, 33'h3);
		repeat (3) begin
			repeat (20) pulse(1'b0);
			pulse(1'b1);
		end
		snap();
		apb(1'b0, STATUS_OFFSET, 32'h0, stat());
		apb(1'b1, CTRL_OFFSET, 32'h0, 33'h0);
		for (int c = 0; c < 2; c++) begin
			if (rq[c].size() > 0) lat[c] = rq[c][$];
			rq[c].delete();
		end
		hold = 2'h0;
		snap();
		apb(1'b0, LATCH1_OFFSET, 32'h0, {13'h0, lat[0]});
		apb(1'b1, STATUS_OFFSET, 32'h300, 33'h0);
		ovf = 2'h0;
		apb(1'b0, STATUS_OFFSET, 32'h0, stat());
		complete_run();
	end
endmodule : lcd_serial_driver_test
bind lcd_serial_driver lcd_driver_properties lcd_driver_properties_i (.clk(clk), .nrst(nrst), .psel(psel),
	.latch_clock_in(latch_clock_in), .shift_clock_in(shift_clock_in), .alternation_in(alternation_in),
	.ch2_mode_strap(ch2_mode_strap), .ch1_direction_strap(ch1_direction_strap), .ch2_direction_strap(ch2_direction_strap),
	.ch1_left_serial_pin_oe(ch1_left_serial_pin_oe), .ch1_right_serial_pin_oe(ch1_right_serial_pin_oe),
	.ch2_left_serial_pin_oe(ch2_left_serial_pin_oe), .ch2_right_serial_pin_oe(ch2_right_serial_pin_oe),
	.drive_outputs(drive_outputs));
`default_nettype wire
